// ===== common/crc_pkg.sv
`default_nettype none
// Shared constants of the comparator reference control block
package crc_pkg;

  // Register index as printed; byte address is four times the index
  localparam logic [11:0] CRC_REF_CTRL_INDEX = 12'hF53;
  localparam logic [31:0] CRC_REF_CTRL_ADDR = {18'h0, CRC_REF_CTRL_INDEX, 2'b00};
  localparam logic [7:0] CRC_REF_CTRL_RESET = 8'h00;

  // Field positions of reference_control
  localparam int CRC_LADDER_ENABLE_BIT = 7;
  localparam int CRC_PIN_OUTPUT_ENABLE_BIT = 6;
  localparam int CRC_RANGE_SELECT_BIT = 5;
  localparam int CRC_SOURCE_SELECT_BIT = 4;
  localparam int CRC_TAP_MSB = 3;
  localparam int CRC_TAP_LSB = 0;

  // Bits kept by a device reset that keeps the source choice
  localparam logic [7:0] CRC_SOFT_RESET_KEEP = 8'h10;

  // Level arithmetic in units of one ninety-sixth of the source
  localparam int CRC_LEVEL_W = 7;
  localparam logic [6:0] CRC_LOW_STEP = 7'h04;
  localparam logic [6:0] CRC_HIGH_STEP = 7'h03;
  localparam logic [6:0] CRC_HIGH_OFFSET = 7'h18;
  localparam logic [6:0] CRC_HIGH_TOP = 7'h45;

  // AHB-Lite encodings
  localparam logic [1:0] CRC_HTRANS_NONSEQ = 2'h2;
  localparam logic CRC_HRESP_OKAY = 1'b0;

endpackage
`default_nettype wire

// ===== rtl/crc_level.sv
`timescale 1ns/1ps
`default_nettype none
// Digital image of the ladder tap: the level in ninety-sixths of the source
module crc_level (
  // Ladder settings
  input wire logic range_select,
  input wire logic [3:0] tap_code,
  // Resulting level
  output logic [crc_pkg::CRC_LEVEL_W-1:0] level_96
);
  import crc_pkg::*;

  logic [6:0] tap_wide;

  // Low range: code/24; high range: 1/4 plus code/32
  always_comb begin
    tap_wide = {3'h0, tap_code};
    if (range_select) begin
      level_96 = 7'(tap_wide * CRC_LOW_STEP);
    end else begin
      level_96 = 7'(CRC_HIGH_OFFSET + tap_wide * CRC_HIGH_STEP);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/crc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Bit 7 powers ladder on or off.
// - Bit 6 connects reference to analog pin.
// - Output enable overrides pin direction setting.
// - Bit 5 picks low or high range.
// - Bit 4 picks external pins or supply.
// - Bits 3..0 are the tap code.
// - Reset clears enable, routing, range, tap.
// - Register survives wake from sleep unchanged.
// - Works regardless of comparator enables.
module crc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device reset that keeps the source choice
  input wire logic device_soft_reset,
  // Pin direction from the port logic, 1 means input
  input wire logic port_direction,
  // Ladder control lines
  output logic ladder_enable,
  output logic range_select,
  output logic source_select,
  output logic [3:0] tap_code,
  // Pin routing
  output logic pin_output_enable,
  output logic pin_analog_connect,
  output logic pin_digital_oe,
  // Selected level in ninety-sixths of the source
  output logic [crc_pkg::CRC_LEVEL_W-1:0] reference_level
);
  import crc_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctrl; // reference_control contents
    logic wr_pend; // Write data phase follows
    logic [31:0] rdata; // Read data for the data phase
    logic [6:0] level; // Registered level image
    logic pin_conn; // Analog switch to the pin
    logic dig_oe; // Digital driver of the pin
    logic ready; // Ready answer
    logic resp; // Response code, registered so the port comes from a flop
  } crc_state_t;

  crc_state_t st_q; // Registered state
  crc_state_t st_d; // Next state
  logic addr_phase; // Valid transfer offered to this slave
  logic hit; // Address matches the control register
  logic [6:0] level_next; // Level for the next control value

  // Level of the next control contents
  crc_level u_level (
    .range_select(st_d.ctrl[CRC_RANGE_SELECT_BIT]),
    .tap_code(st_d.ctrl[CRC_TAP_MSB:CRC_TAP_LSB]),
    .level_96(level_next)
  );

  // Address phase qualification
  // Only the exact word address decodes; hsize is not checked, so any
  // access size to this word acts on the whole control byte
  assign addr_phase = hsel && hready && htrans[1];
  assign hit = (haddr == CRC_REF_CTRL_ADDR);

  // Next state: bus decode, register update, pin routing
  // The level instance reads st_d.ctrl, so the level image and the control
  // bits change on the same edge
  always_comb begin
    st_d = st_q;
    st_d.ready = 1'b1;
    st_d.resp = CRC_HRESP_OKAY;
    // Write data phase lands the byte; every bit is writable
    if (st_q.wr_pend && hready) begin
      st_d.ctrl = hwdata[7:0];
    end
    // Device reset wipes all but the source choice
    // Applied after the write so that it wins a tie in one cycle
    if (device_soft_reset) begin
      st_d.ctrl = st_q.ctrl & CRC_SOFT_RESET_KEEP;
    end
    // Nothing else touches the register, sleep included
    // New address phase
    if (hready) begin
      st_d.wr_pend = addr_phase && hwrite && hit;
    end
    if (addr_phase && !hwrite) begin
      // Reads see a write finishing in the same cycle
      st_d.rdata = hit ? {24'h0, st_d.ctrl} : 32'h0;
    end
    st_d.level = level_next;
    st_d.pin_conn = st_d.ctrl[CRC_PIN_OUTPUT_ENABLE_BIT];
    // Reference on the pin beats the port direction
    st_d.dig_oe = !st_d.ctrl[CRC_PIN_OUTPUT_ENABLE_BIT] && !port_direction;
  end

  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
      st_q.ctrl <= CRC_REF_CTRL_RESET;
      // Level image of the cleared high range at tap zero
      st_q.level <= CRC_HIGH_OFFSET;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = st_q.ready;
  assign hresp = st_q.resp;
  assign hrdata = st_q.rdata;
  assign ladder_enable = st_q.ctrl[CRC_LADDER_ENABLE_BIT];
  assign pin_output_enable = st_q.ctrl[CRC_PIN_OUTPUT_ENABLE_BIT];
  assign range_select = st_q.ctrl[CRC_RANGE_SELECT_BIT];
  assign source_select = st_q.ctrl[CRC_SOURCE_SELECT_BIT];
  assign tap_code = st_q.ctrl[CRC_TAP_MSB:CRC_TAP_LSB];
  assign pin_analog_connect = st_q.pin_conn;
  assign pin_digital_oe = st_q.dig_oe;
  assign reference_level = st_q.level;

  // Checks on the design's own behaviour
  // One clock domain, so all checks share one clocking; all but a_reset_clear share one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // A write data phase sets the register at the following edge
  a_write_lands: assert property (
    (st_q.wr_pend && hready && !device_soft_reset)
      |=> (ladder_enable == $past(hwdata[7])) && (tap_code == $past(hwdata[3:0]))
          && (source_select == $past(hwdata[4])) && (range_select == $past(hwdata[5]))
          && (pin_output_enable == $past(hwdata[6])))
    else $error("write data not stored");

  // A write address phase to the register opens a data phase
  a_pend_sets: assert property (
    (addr_phase && hwrite && hit) |=> st_q.wr_pend)
    else $error("write address phase not taken");

  // Anything else on a ready bus closes the data phase
  a_pend_clears: assert property (
    (hready && !(addr_phase && hwrite && hit)) |=> !st_q.wr_pend)
    else $error("stray write data phase");

  // Read data stands until the next read address phase
  a_rdata_stands: assert property (
    !(addr_phase && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  // Reset holds every control line and the read data cleared
  a_reset_clear: assert property (
    disable iff (1'b0)
    reset |=> !ladder_enable && !pin_output_enable && !range_select && !source_select
      && tap_code == 4'h0 && !pin_analog_connect && !pin_digital_oe && hrdata == 32'h0)
    else $error("reset left outputs set");

  // A read of the register returns its contents in the data phase
  a_read_returns: assert property (
    (addr_phase && !hwrite && hit)
      |=> hrdata == {24'h0, ladder_enable, pin_output_enable, range_select,
                     source_select, tap_code})
    else $error("read data differs from register");

  // Unmapped reads give zero
  a_unmapped_zero: assert property (
    (addr_phase && !hwrite && !hit) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");

  // Device reset clears all but the source bit
  a_soft_reset: assert property (
    device_soft_reset |=> !ladder_enable && !pin_output_enable && !range_select
      && tap_code == 4'h0 && source_select == $past(source_select))
    else $error("device reset left bits set");

  // With no write and no reset the contents hold, e.g. across sleep
  a_ctrl_holds: assert property (
    !(st_q.wr_pend && hready) && !device_soft_reset |=> $stable(st_q.ctrl))
    else $error("register changed without a write");

  // Reference on the pin always disables the digital driver
  a_pin_override: assert property (
    pin_output_enable |-> !pin_digital_oe && pin_analog_connect)
    else $error("digital driver active with reference on pin");

  // Without the reference the port direction rules the driver
  a_pin_direction: assert property (
    (!pin_output_enable && !$past(reset))
      |-> !pin_analog_connect && (pin_digital_oe == !$past(port_direction)))
    else $error("pin routing wrong with output disabled");

  // Low range level is four ninety-sixths per tap
  a_low_level: assert property (
    range_select |-> reference_level == 7'(tap_code * 3'h4))
    else $error("low range level wrong");

  // High range level is a quarter plus three ninety-sixths per tap
  a_high_level: assert property (
    !range_select |-> reference_level >= CRC_HIGH_OFFSET && reference_level <= CRC_HIGH_TOP
      && reference_level == 7'(CRC_HIGH_OFFSET + tap_code * CRC_HIGH_STEP))
    else $error("high range level wrong");

  // No setting takes the level above three quarters of the source
  a_level_range: assert property (
    reference_level <= CRC_HIGH_TOP)
    else $error("level above top of ladder");

  // The slave never stalls and always answers OKAY
  a_bus_okay: assert property (
    hreadyout && hresp == CRC_HRESP_OKAY)
    else $error("slave stalled or errored");

endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import crc_pkg::*;
  // One table row: bus write data, expected read-back byte and level
  typedef struct packed {logic [31:0] wd; logic [7:0] rd; logic [6:0] lv;} crc_row_t;
  // Stimulus and bus lines
  logic clk, reset, hsel, hwrite, device_soft_reset, port_direction;
  logic [31:0] haddr, hwdata, rdv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  // Design outputs
  logic hreadyout, hresp, ladder_enable, range_select, source_select;
  logic pin_output_enable, pin_analog_connect, pin_digital_oe;
  logic [31:0] hrdata;
  logic [3:0] tap_code;
  logic [6:0] reference_level;
  int err_count, checks;
  // Ordinary cases, upper data bits must be dropped in the last row
  crc_row_t rows [6] = '{'{32'hA5, 8'hA5, 7'h14}, '{32'h8F, 8'h8F, 7'h45},
    '{32'hF0, 8'hF0, 7'h00}, '{32'h40, 8'h40, 7'h18}, '{32'h3C, 8'h3C, 7'h30},
    '{32'hFFFFFF5A, 8'h5A, 7'h36}};
  crc_top dut_u (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .device_soft_reset(device_soft_reset), .port_direction(port_direction),
    .ladder_enable(ladder_enable), .range_select(range_select),
    .source_select(source_select), .tap_code(tap_code),
    .pin_output_enable(pin_output_enable), .pin_analog_connect(pin_analog_connect),
    .pin_digital_oe(pin_digital_oe), .reference_level(reference_level));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Single compare for every result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One AHB-Lite single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= CRC_HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, CRC_HRESP_OKAY});
  endtask
  // Control lines and level after the edge, then realign to the next edge
  task automatic chk_out(input logic [7:0] v, input logic [6:0] lv);
    #1;
    chk({24'h0, ladder_enable, pin_output_enable, range_select, source_select, tap_code},
        {24'h0, v});
    chk({25'h0, reference_level}, {25'h0, lv});
    @(posedge clk);
  endtask
  // Pin routing one edge after a direction change
  task automatic pin(input logic pd, input logic oe, input logic an);
    port_direction <= pd;
    @(posedge clk);
    #1 chk({30'h0, pin_digital_oe, pin_analog_connect}, {30'h0, oe, an});
    @(posedge clk);
  endtask
  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    device_soft_reset = 1'b0;
    port_direction = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    chk_out(8'h00, 7'h18);
    bus(1'b0, CRC_REF_CTRL_ADDR, '0, rdv);
    chk(rdv, 32'h0);
    $display("test reset_values done");
    foreach (rows[i]) begin
      bus(1'b1, CRC_REF_CTRL_ADDR, rows[i].wd, rdv);
      chk_out(rows[i].rd, rows[i].lv);
      bus(1'b0, CRC_REF_CTRL_ADDR, '0, rdv);
      chk(rdv, {24'h0, rows[i].rd});
    end
    $display("test table done");
    bus(1'b1, CRC_REF_CTRL_ADDR, 32'h00, rdv);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b1, 1'b0, 1'b0);
    bus(1'b1, CRC_REF_CTRL_ADDR, 32'h40, rdv);
    pin(1'b0, 1'b0, 1'b1);
    pin(1'b1, 1'b0, 1'b1);
    $display("test pin_override done");
    bus(1'b1, CRC_REF_CTRL_ADDR, 32'hFF, rdv);
    device_soft_reset <= 1'b1;
    @(posedge clk);
    device_soft_reset <= 1'b0;
    chk_out(8'h10, 7'h18);
    bus(1'b0, CRC_REF_CTRL_ADDR, '0, rdv);
    chk(rdv, 32'h10);
    $display("test soft_reset done");
    // Ladder off before the idle stretch that stands for sleep
    bus(1'b1, CRC_REF_CTRL_ADDR, 32'h1B, rdv);
    repeat (50) @(posedge clk);
    chk_out(8'h1B, 7'h39);
    bus(1'b1, CRC_REF_CTRL_ADDR + 32'h4, 32'hFF, rdv);
    bus(1'b0, CRC_REF_CTRL_ADDR + 32'h4, '0, rdv);
    chk(rdv, 32'h0);
    bus(1'b0, CRC_REF_CTRL_ADDR, '0, rdv);
    chk(rdv, 32'h1B);
    $display("test hold_and_unmapped done");
    reset <= 1'b1;
    chk_out(8'h00, 7'h18);
    chk(hrdata, 32'h0);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, CRC_REF_CTRL_ADDR, '0, rdv);
    chk(rdv, 32'h0);
    $display("test async_reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
